// ==== srt_defs.vh ====
// Constants shared by the selectable rate tick clock design files.
`ifndef SRT_DEFS_VH
`define SRT_DEFS_VH

`define SRT_AW           5
`define SRT_REG_ACC      5'h00
`define SRT_REG_INSTR    5'h04
`define SRT_REG_MASK     5'h08
`define SRT_REG_STATUS   5'h0c
`define SRT_REG_RESET    5'h10

`define SRT_DEV_CODE     6'h0c
`define SRT_MASK_BIT     13

`define SRT_I_DEV_HI     5
`define SRT_I_DEV_LO     0
`define SRT_I_FLAG_HI    7
`define SRT_I_FLAG_LO    6
`define SRT_I_OP_HI      10
`define SRT_I_OP_LO      8

`define SRT_F_NONE       2'h0
`define SRT_F_START      2'h1
`define SRT_F_CLEAR      2'h2
`define SRT_F_PULSE      2'h3

`define SRT_OP_NIO       3'h0
`define SRT_OP_DOA       3'h2

`define SRT_RATE_HI      1
`define SRT_RATE_LO      0
`define SRT_RATE_LINE    2'h0
`define SRT_RATE_10HZ    2'h1
`define SRT_RATE_100HZ   2'h2
`define SRT_RATE_1KHZ    2'h3

`define SRT_ST_BUSY      0
`define SRT_ST_DONE      1
`define SRT_ST_IRQ       2
`define SRT_ST_RATE_LO   4

`define SRT_RST_PROG     0
`define SRT_RST_CONSOLE  1

`define SRT_DECADE_LAST  4'h9
`define SRT_DECADE_ZERO  4'h0

`endif

// ==== srt_xtal_div.v ====
// Crystal divider producing free-running 1000, 100 and 10 Hz tick pulses.
`timescale 1ns/1ps
`default_nettype none
`include "srt_defs.vh"

module srt_xtal_div #(
  parameter             DIV_W       = 10,
  parameter [DIV_W-1:0] XTAL_PER_MS = 10'h3e8
) (
  input  wire core_clk,
  input  wire reset,
  input  wire clk_en,
  input  wire xtal_in,
  output reg  tick_1k,
  output reg  tick_100,
  output reg  tick_10
);

  localparam [DIV_W-1:0] MS_LAST = XTAL_PER_MS - {{(DIV_W-1){1'b0}}, 1'b1};
  localparam [DIV_W-1:0] MS_ZERO = {DIV_W{1'b0}};

  reg             xtal_q;
  reg [DIV_W-1:0] ms_cnt;
  reg [3:0]       dec_100;
  reg [3:0]       dec_10;
  wire            xtal_edge;
  wire            ms_wrap;

  // Every rising crystal edge counts, so a ragged pulse train during warm-up only skews timing.
  assign xtal_edge = xtal_in & ~xtal_q;
  assign ms_wrap   = xtal_edge && (ms_cnt == MS_LAST);

  // The chain never restarts on a start request, so the first tick lands anywhere in a period.
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      xtal_q   <= 1'b0;
      ms_cnt   <= MS_ZERO;
      dec_100  <= `SRT_DECADE_ZERO;
      dec_10   <= `SRT_DECADE_ZERO;
      tick_1k  <= 1'b0;
      tick_100 <= 1'b0;
      tick_10  <= 1'b0;
    end
    else if (clk_en)
    begin
      xtal_q   <= xtal_in;
      tick_1k  <= ms_wrap;
      tick_100 <= ms_wrap && (dec_100 == `SRT_DECADE_LAST);
      tick_10  <= ms_wrap && (dec_100 == `SRT_DECADE_LAST)
                  && (dec_10 == `SRT_DECADE_LAST);
      if (xtal_edge)
      begin
        ms_cnt <= ms_wrap ? MS_ZERO : ms_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
      end
      if (ms_wrap)
      begin
        dec_100 <= (dec_100 == `SRT_DECADE_LAST) ? `SRT_DECADE_ZERO : dec_100 + 4'h1;
        if (dec_100 == `SRT_DECADE_LAST)
        begin
          dec_10 <= (dec_10 == `SRT_DECADE_LAST) ? `SRT_DECADE_ZERO : dec_10 + 4'h1;
        end
      end
    end
  end

endmodule // srt_xtal_div

`default_nettype wire

// ==== srt_tick_clock.v ====
// Selectable rate tick clock with an Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none
`include "srt_defs.vh"

module srt_tick_clock #(
  parameter             DIV_W       = 10,
  parameter [DIV_W-1:0] XTAL_PER_MS = 10'h3e8
) (
  input  wire                core_clk,
  input  wire                reset,
  input  wire                clk_en,
  input  wire [`SRT_AW-1:0]  avs_address,
  input  wire                avs_read,
  input  wire                avs_write,
  input  wire [31:0]         avs_writedata,
  input  wire [3:0]          avs_byteenable,
  output reg  [31:0]         avs_readdata,
  output reg                 avs_waitrequest,
  input  wire                line_freq_in,
  input  wire                xtal_in,
  output reg                 int_req,
  output reg                 tick_busy,
  output reg                 tick_done
);

  reg  [15:0] acc;
  reg  [15:0] mask;
  reg  [1:0]  rate;
  reg         line_q;
  reg  [15:0] next_acc;
  reg  [15:0] next_mask;
  reg  [1:0]  next_rate;
  reg         next_busy;
  reg         next_done;
  reg  [31:0] next_readdata;
  reg         sel_tick;
  reg  [15:0] instr;
  wire        tick_1k;
  wire        tick_100;
  wire        tick_10;
  wire        line_tick;
  wire        wr_fire;
  wire        rd_take;
  wire        instr_hit;
  wire        io_reset;

  // Merges the low two byte lanes of a bus write into a 16-bit register.
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0]  be;
    begin
      merge16 = old;
      if (be[0])
      begin
        merge16[7:0] = wd[7:0];
      end
      if (be[1])
      begin
        merge16[15:8] = wd[15:8];
      end
    end
  endfunction

  srt_xtal_div #(
    .DIV_W       (DIV_W),
    .XTAL_PER_MS (XTAL_PER_MS)
  ) u_div (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .xtal_in  (xtal_in),
    .tick_1k  (tick_1k),
    .tick_100 (tick_100),
    .tick_10  (tick_10)
  );

  // Mains pulses need no warm-up, so they are usable straight after reset.
  assign line_tick = line_freq_in & ~line_q;

  // A write takes effect only at the edge where waitrequest is seen low.
  assign wr_fire   = avs_write & ~avs_waitrequest;
  assign rd_take   = (avs_read | avs_write) & avs_waitrequest;
  assign instr_hit = wr_fire && (avs_address == `SRT_REG_INSTR)
                     && (instr[`SRT_I_DEV_HI:`SRT_I_DEV_LO] == `SRT_DEV_CODE);
  assign io_reset  = wr_fire && (avs_address == `SRT_REG_RESET)
                     && (avs_writedata[`SRT_RST_PROG] | avs_writedata[`SRT_RST_CONSOLE]);

  always @*
  begin
    instr = merge16(16'h0000, avs_writedata, avs_byteenable);
    case (rate)
      `SRT_RATE_LINE:  sel_tick = line_tick;
      `SRT_RATE_10HZ:  sel_tick = tick_10;
      `SRT_RATE_100HZ: sel_tick = tick_100;
      `SRT_RATE_1KHZ:  sel_tick = tick_1k;
      default:         sel_tick = 1'b0;
    endcase
  end

  always @*
  begin
    next_acc  = acc;
    next_mask = mask;
    next_rate = rate;
    next_busy = tick_busy;
    next_done = tick_done;
    if (wr_fire && (avs_address == `SRT_REG_ACC))
    begin
      next_acc = merge16(acc, avs_writedata, avs_byteenable);
    end
    if (wr_fire && (avs_address == `SRT_REG_MASK))
    begin
      next_mask = merge16(mask, avs_writedata, avs_byteenable);
    end
    if (instr_hit)
    begin
      if (instr[`SRT_I_OP_HI:`SRT_I_OP_LO] == `SRT_OP_DOA)
      begin
        next_rate = acc[`SRT_RATE_HI:`SRT_RATE_LO];
      end
      case (instr[`SRT_I_FLAG_HI:`SRT_I_FLAG_LO])
        `SRT_F_START:
        begin
          next_busy = 1'b1;
          next_done = 1'b0;
        end
        `SRT_F_CLEAR:
        begin
          next_busy = 1'b0;
          next_done = 1'b0;
        end
        default:
        begin
          next_busy = next_busy;
        end
      endcase
    end
    if (io_reset)
    begin
      next_rate = `SRT_RATE_LINE;
      next_busy = 1'b0;
      next_done = 1'b0;
    end
    // The tick is applied last so a tick in the same cycle as a clear is not lost.
    if (sel_tick && tick_busy)
    begin
      next_done = 1'b1;
      next_busy = 1'b0;
    end
  end

  always @*
  begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      `SRT_REG_ACC:
      begin
        next_readdata[15:0] = acc;
      end
      `SRT_REG_MASK:
      begin
        next_readdata[15:0] = mask;
      end
      `SRT_REG_STATUS:
      begin
        next_readdata[`SRT_ST_BUSY]                 = tick_busy;
        next_readdata[`SRT_ST_DONE]                 = tick_done;
        next_readdata[`SRT_ST_IRQ]                  = int_req;
        next_readdata[`SRT_ST_RATE_LO+1:`SRT_ST_RATE_LO] = rate;
      end
      default:
      begin
        next_readdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      acc             <= 16'h0000;
      mask            <= 16'h0000;
      rate            <= `SRT_RATE_LINE;
      line_q          <= 1'b0;
      tick_busy       <= 1'b0;
      tick_done       <= 1'b0;
      int_req         <= 1'b0;
    end
    else if (clk_en)
    begin
      // One wait state per access keeps read data a registered copy of the state.
      if (rd_take)
      begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= avs_read ? next_readdata : 32'h0000_0000;
      end
      else
      begin
        avs_waitrequest <= 1'b1;
      end
      acc       <= next_acc;
      mask      <= next_mask;
      rate      <= next_rate;
      line_q    <= line_freq_in;
      tick_busy <= next_busy;
      tick_done <= next_done;
      int_req   <= next_done & ~next_mask[`SRT_MASK_BIT];
    end
  end

endmodule // srt_tick_clock

`default_nettype wire

// ==== srt_tick_clock_properties.sv ====
// Port-level checker for the selectable rate tick clock.
`timescale 1ns/1ps
`default_nettype none
`include "srt_defs.vh"
module srt_tick_clock_properties (
  input wire logic               core_clk,
  input wire logic               reset,
  input wire logic               clk_en,
  input wire logic [`SRT_AW-1:0] avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [3:0]         avs_byteenable,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  input wire logic               line_freq_in,
  input wire logic               xtal_in,
  input wire logic               int_req,
  input wire logic               tick_busy,
  input wire logic               tick_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire acc_w = avs_write && !avs_waitrequest;
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop after one cycle");
  busy_rise_a: assert property ($rose(tick_busy) |-> $past(acc_w))
    else $error("busy rose without a write");
  busy_fall_a: assert property ($fell(tick_busy) |-> tick_done || $past(acc_w))
    else $error("busy fell without tick or write");
  done_rise_a: assert property ($rose(tick_done) |-> $past(tick_busy))
    else $error("done rose while not busy");
  irq_done_a: assert property (int_req |-> tick_done)
    else $error("interrupt without done");
  irq_rise_a: assert property ($rose(int_req) |-> $rose(tick_done) || $past(acc_w)
    || $past(acc_w, 2))
    else $error("interrupt rose without cause");
  status_rd_a: assert property (avs_read && !avs_waitrequest && avs_address == `SRT_REG_STATUS
    |-> avs_readdata[2:0] == $past({int_req, tick_done, tick_busy}))
    else $error("status flags wrong");
  unmapped_rd_a: assert property (avs_read && !avs_waitrequest && avs_address > 5'h10
    |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  reset_val_a: assert property (disable iff (1'b0) reset
    |-> avs_waitrequest && !tick_busy && !tick_done && !int_req)
    else $error("outputs not cleared in reset");
  cover property ($rose(tick_done) && int_req);
  cover property ($rose(tick_done) && !int_req);
  cover property ($fell(tick_busy) && !tick_done);
endmodule // srt_tick_clock_properties
`default_nettype wire

// ==== srt_host_model.sv ====
// Host processor model issuing programmed I/O over the Avalon-MM slave.
`timescale 1ns/1ps
`default_nettype none
`include "srt_defs.vh"
module srt_host_model (
  input  wire logic               core_clk,
  input  wire logic               avs_waitrequest,
  input  wire logic [31:0]        avs_readdata,
  output var  logic [`SRT_AW-1:0] avs_address,
  output var  logic               avs_read,
  output var  logic               avs_write,
  output var  logic [31:0]        avs_writedata
);
  initial
  begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
  end
  // Held until waitrequest is sampled low; the slave's wait length is never assumed.
  task automatic acc(input logic w, input logic [`SRT_AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest) @(posedge core_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Return once the flags updated at the accepting edge have settled.
    @(negedge core_clk);
  endtask
  // Operation, flag function and device code packed into one word.
  task automatic ins(input logic [1:0] fn, input logic [2:0] op, input logic [5:0] dev);
    logic [31:0] q;
    acc(1'b1, `SRT_REG_INSTR, {21'h0, op, fn, dev}, q);
  endtask
endmodule // srt_host_model
`default_nettype wire

// ==== test_selectable_rate_tick_clock.sv ====
// Self-checking testbench for the selectable rate tick clock.
`timescale 1ns/1ps
`default_nettype none
`include "srt_defs.vh"
module test_selectable_rate_tick_clock;
  typedef struct { logic [1:0] rate; int lim; } srt_row_t;
  srt_row_t rows [4] = '{'{2'h0, 1}, '{2'h1, 400}, '{2'h2, 40}, '{2'h3, 4}};
  logic core_clk, reset, line_freq_in, xtal_in;
  wire [4:0] avs_address;
  wire avs_read, avs_write, avs_waitrequest, int_req, tick_busy, tick_done;
  wire [31:0] avs_writedata, avs_readdata;
  logic [31:0] q;
  int n_fail, samples_checked, cyc, i;
  srt_tick_clock #(.DIV_W(10), .XTAL_PER_MS(10'h004)) u_dut (.core_clk, .reset,
    .clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .line_freq_in, .xtal_in,
    .int_req, .tick_busy, .tick_done);
  srt_host_model u_host (.core_clk, .avs_waitrequest, .avs_readdata, .avs_address,
    .avs_read, .avs_write, .avs_writedata);
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = !core_clk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      final_report;
    end
  end
  // The flag is taken at the call; bus tasks return only after their updates have settled.
  task automatic chk_bit(input logic g, input logic e);
    repeat (2) @(negedge core_clk);
    samples_checked++;
    if (g !== e) begin n_fail++; $display("mismatch at %0t flag %b", $time, g); end
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin n_fail++; $display("mismatch at %0t word %h", $time, g); end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    u_host.acc(1'b1, a, d, q);
  endtask
  task automatic pulse(input logic line);
    @(posedge core_clk);
    if (line) line_freq_in <= 1'b1;
    else xtal_in <= 1'b1;
    @(posedge core_clk);
    line_freq_in <= 1'b0;
    xtal_in <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic tick_wait(input logic line, input int lim);
    int n;
    n = 0;
    while (tick_done !== 1'b1 && n <= lim) begin pulse(line); n++; end
    chk_bit(tick_done, 1'b1);
    chk_bit(n <= lim, 1'b1);
  endtask
  initial
  begin
    reset = 1'b1;
    line_freq_in = 1'b0;
    xtal_in = 1'b0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      wr(`SRT_REG_ACC, {30'h0, rows[i].rate});
      u_host.ins(`SRT_F_START, `SRT_OP_DOA, `SRT_DEV_CODE);
      if (rows[i].rate == `SRT_RATE_LINE) begin repeat (8) pulse(1'b0); end
      chk_bit(tick_done, 1'b0);
      tick_wait(rows[i].rate == `SRT_RATE_LINE, rows[i].lim);
      chk_bit(int_req, 1'b1);
      u_host.ins(`SRT_F_START, `SRT_OP_NIO, `SRT_DEV_CODE);
      u_host.acc(1'b0, `SRT_REG_STATUS, 32'h0, q);
      chk_word(q, {26'h0, rows[i].rate, 4'h1});
      u_host.ins(`SRT_F_CLEAR, `SRT_OP_NIO, `SRT_DEV_CODE);
      chk_bit(tick_busy, 1'b0);
      $display("test rate row %0d done", i);
    end
    wr(`SRT_REG_MASK, 32'h0000_2000);
    u_host.ins(`SRT_F_START, `SRT_OP_NIO, `SRT_DEV_CODE);
    tick_wait(1'b0, 4);
    chk_bit(int_req, 1'b0);
    wr(`SRT_REG_MASK, 32'h0000_0000);
    chk_bit(int_req, 1'b1);
    u_host.ins(`SRT_F_CLEAR, `SRT_OP_NIO, `SRT_DEV_CODE);
    chk_bit(int_req, 1'b0);
    chk_bit(tick_done, 1'b0);
    u_host.ins(`SRT_F_START, `SRT_OP_NIO, 6'h0d);
    chk_bit(tick_busy, 1'b0);
    u_host.acc(1'b0, 5'h14, 32'h0, q);
    chk_word(q, 32'h0000_0000);
    $display("test mask and refusals done");
    for (i = 0; i < 2; i++)
    begin
      u_host.ins(`SRT_F_START, `SRT_OP_DOA, `SRT_DEV_CODE);
      wr(`SRT_REG_RESET, 32'h1 << i);
      u_host.acc(1'b0, `SRT_REG_STATUS, 32'h0, q);
      chk_word(q, 32'h0000_0000);
      wr(`SRT_REG_ACC, 32'h0000_0003);
    end
    u_host.ins(`SRT_F_START, `SRT_OP_DOA, `SRT_DEV_CODE);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    u_host.acc(1'b0, `SRT_REG_STATUS, 32'h0, q);
    chk_word(q, 32'h0000_0000);
    u_host.ins(`SRT_F_START, `SRT_OP_NIO, `SRT_DEV_CODE);
    tick_wait(1'b1, 1);
    $display("test resets done");
    final_report;
  end
endmodule // test_selectable_rate_tick_clock
bind srt_tick_clock srt_tick_clock_properties u_props (.core_clk, .reset, .clk_en,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .line_freq_in, .xtal_in, .int_req, .tick_busy, .tick_done);
`default_nettype wire
